/* File: src/adc_conv_seq.sv */
// Conversion sequencer with Wishbone register slave
// Summary of operation
// - Bias scaled by (1 - low3/8), divided by four when bit 3 set.
// - Scan runs first on simultaneous triggers or during single warm-up.
// - Scan waits for a single already acquiring or approximating.
// - With tail follow, triggered single waits for next scan end.
// - Each mode has one-shot or repeat operation by its own control.
// - Command start or stop per mode; start wins over stop.
// - Stop mid conversion discards partial result; FIFO kept.
// - Active flag high while converting or pending; set on write.
// - Event triggers synchronised before setting active flag.
// - Start or trigger ignored while the mode is already active.
// - Pulse style trigger behaves as a start; sampling ends on AT.
// - Timed style: falling event edge ends sampling if high at AT end.
// - Timed style: event already low at AT end adds two cycles.
// - Optional analog start delay of 0 to 8 microseconds.
// - On-demand clock request; clock runs 5 or 7 + OSC_SLOW cycles later.
// - Timed style: event still high after stop retriggers the mode.
// - Trigger while idle resets approximation clock phase.
`timescale 1ns/1ps
`default_nettype none
module adc_conv_seq
  import adc_seq_pkg::*;
#(
  parameter int OSC_SLOW = 1
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  input wire logic I_WB_WE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic [NUM_CH-1:0] I_EVENT,
  input wire logic I_OSC_RUNNING,
  input wire logic I_REF_OVERVOLTAGE,
  output logic O_CLK_REQ,
  output logic O_ANALOG_EN,
  output logic O_SAMPLE,
  output logic O_SAR_PHASE_RST,
  output logic O_CONV_DONE,
  output logic O_CONV_IS_SCAN,
  output logic O_DISCARD_PARTIAL,
  output logic O_SINGLE_FLUSH,
  output logic O_SCAN_FLUSH,
  output logic [5:0] O_BIAS_SCALE,
  output logic O_REF_FAULT_CLEAR
);
  // ****************************************
  // Register file
  // ****************************************
  logic [CFG_W-1:0] sgl_cfg_reg, sgl_cfg_next;
  logic [CFG_W-1:0] scn_cfg_reg, scn_cfg_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [8:0] bias_reg, bias_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic wr_stb;
  logic [31:0] cmd;

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  assign wr_stb = I_WB_CYC & I_WB_STB & I_WB_WE & ~ack_reg;
  assign cmd = (wr_stb && I_WB_ADR == CMD_OFS) ?
               (I_WB_DAT & {{24{1'b0}}, {8{I_WB_SEL[0]}}}) : 32'h0;

  // ****************************************
  // Sequencer state
  // ****************************************
  seq_state_t st_reg, st_next;
  logic sgl_act_reg, sgl_act_next;
  logic scn_act_reg, scn_act_next;
  logic cur_scan_reg, cur_scan_next;
  logic tail_wait_reg, tail_wait_next;
  logic clk_req_reg, clk_req_next;
  logic [11:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic disc_reg, disc_next;
  logic phase_rst_reg, phase_rst_next;
  logic sgl_lvl, sgl_rise, scn_lvl, scn_rise;
  logic sgl_trig, scn_trig, sgl_stop, scn_stop;
  logic [CFG_W-1:0] cur_cfg;

  adc_trig_sync u_sync_sgl (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_async(I_EVENT),
    .i_sel(sgl_cfg_reg[CHSEL_LSB +: CHSEL_W]),
    .o_level(sgl_lvl),
    .o_rise(sgl_rise)
  );

  adc_trig_sync u_sync_scn (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_async(I_EVENT),
    .i_sel(scn_cfg_reg[CHSEL_LSB +: CHSEL_W]),
    .o_level(scn_lvl),
    .o_rise(scn_rise)
  );

  adc_bias_scale u_bias (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_field(bias_reg[BIAS_LSB +: BIAS_W]),
    .o_scale(O_BIAS_SCALE)
  );

  // Start from command or from a synchronised event
  // Timed style: event level still high after a stop counts as a new trigger
  always_comb begin
    sgl_trig = cmd[SINGLE_GO_BIT] | (sgl_cfg_reg[TRIG_EN_BIT] &
               (sgl_cfg_reg[TRIG_STYLE_BIT] ? sgl_lvl : sgl_rise));
    scn_trig = cmd[SCAN_GO_BIT] | (scn_cfg_reg[TRIG_EN_BIT] &
               (scn_cfg_reg[TRIG_STYLE_BIT] ? scn_lvl : scn_rise));
    sgl_stop = cmd[SINGLE_HALT_BIT] & ~sgl_trig;
    scn_stop = cmd[SCAN_HALT_BIT] & ~scn_trig;
  end

  always_comb begin
    cur_cfg = cur_scan_reg ? scn_cfg_reg : sgl_cfg_reg;
  end

  always_comb begin
    sgl_cfg_next = sgl_cfg_reg;
    scn_cfg_next = scn_cfg_reg;
    ctrl_next = ctrl_reg;
    bias_next = bias_reg;
    ack_next = I_WB_CYC & I_WB_STB & ~ack_reg;
    rdat_next = 32'h0;
    if (wr_stb) begin
      case (I_WB_ADR)
        SINGLE_CFG_OFS: sgl_cfg_next = CFG_W'(wmask(32'(sgl_cfg_reg),
                                              I_WB_DAT, I_WB_SEL));
        SCAN_CFG_OFS: scn_cfg_next = CFG_W'(wmask(32'(scn_cfg_reg),
                                            I_WB_DAT, I_WB_SEL));
        CTRL_OFS: ctrl_next = 3'(wmask(32'(ctrl_reg), I_WB_DAT, I_WB_SEL));
        BIAS_OFS: bias_next = 9'(wmask(32'(bias_reg), I_WB_DAT, I_WB_SEL));
        default: ;
      endcase
    end
    case (I_WB_ADR)
      STATUS_OFS: begin
        rdat_next[SINGLE_ACT_BIT] = sgl_act_reg;
        rdat_next[SCAN_ACT_BIT] = scn_act_reg;
        rdat_next[CLK_REQ_BIT] = clk_req_reg;
        rdat_next[ANALOG_EN_BIT] = O_ANALOG_EN;
        rdat_next[BUSY_SINGLE_BIT] = st_reg != ST_IDLE && !cur_scan_reg;
        rdat_next[BUSY_SCAN_BIT] = st_reg != ST_IDLE && cur_scan_reg;
      end
      SINGLE_CFG_OFS: rdat_next = 32'(sgl_cfg_reg);
      SCAN_CFG_OFS: rdat_next = 32'(scn_cfg_reg);
      CTRL_OFS: rdat_next = 32'(ctrl_reg);
      BIAS_OFS: rdat_next = 32'(bias_reg);
      default: rdat_next = 32'h0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      sgl_cfg_reg <= CFG_RST;
      scn_cfg_reg <= CFG_RST;
      ctrl_reg <= 3'h0;
      bias_reg <= 9'h000;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      sgl_cfg_reg <= sgl_cfg_next;
      scn_cfg_reg <= scn_cfg_next;
      ctrl_reg <= ctrl_next;
      bias_reg <= bias_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // ****************************************
  // Arbitration and conversion sequence
  // ****************************************
  always_comb begin
    st_next = st_reg;
    sgl_act_next = sgl_act_reg;
    scn_act_next = scn_act_reg;
    cur_scan_next = cur_scan_reg;
    tail_wait_next = tail_wait_reg;
    clk_req_next = clk_req_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    disc_next = 1'b0;
    phase_rst_next = 1'b0;
    // Accept triggers only for an inactive mode
    if (sgl_trig && !sgl_act_reg) begin
      sgl_act_next = 1'b1;
      tail_wait_next = ctrl_reg[TAIL_BIT];
    end
    if (scn_trig && !scn_act_reg) begin
      scn_act_next = 1'b1;
    end
    case (st_reg)
      ST_IDLE: begin
        if (scn_act_reg || (sgl_act_reg && !tail_wait_reg)) begin
          cur_scan_next = scn_act_reg;
          phase_rst_next = 1'b1;
          clk_req_next = ctrl_reg[DEMAND_BIT];
          cnt_next = ctrl_reg[DEMAND_BIT] ? (I_OSC_RUNNING ?
                     12'(CLK_START_CYC) : 12'(OSC_START_CYC + OSC_SLOW)) :
                     12'h0;
          st_next = ST_CLKWAIT;
        end
      end
      ST_CLKWAIT: begin
        // Warm-up phase: a later scan still takes the slot
        if (scn_act_reg) begin
          cur_scan_next = 1'b1;
        end
        if (cnt_reg == 12'h0) begin
          cnt_next = cur_cfg[DLY_EN_BIT] ? 12'(CYC_PER_US *
                     32'(cur_cfg[DLY_LSB +: DLY_W] > 4'(DLY_MAX_US) ?
                     4'(DLY_MAX_US) : cur_cfg[DLY_LSB +: DLY_W])) : 12'h0;
          st_next = ST_DELAY;
        end else begin
          cnt_next = cnt_reg - 12'h1;
        end
      end
      ST_DELAY: begin
        if (cnt_reg == 12'h0) begin
          cnt_next = 12'(cur_cfg[AT_LSB +: AT_W]);
          st_next = ST_ACQ;
        end else begin
          cnt_next = cnt_reg - 12'h1;
        end
      end
      ST_ACQ: begin
        if (cnt_reg == 12'h0) begin
          if (cur_cfg[TRIG_EN_BIT] && cur_cfg[TRIG_STYLE_BIT]) begin
            cnt_next = 12'(TIMED_EXTRA_CYC);
            st_next = ST_HOLD;
          end else begin
            cnt_next = 12'(SAR_CYC);
            st_next = ST_SAR;
          end
        end else begin
          cnt_next = cnt_reg - 12'h1;
        end
      end
      ST_HOLD: begin
        // Event high at AT end: wait for falling edge
        // Event low at AT end: fixed two-cycle latency
        if ((cur_scan_reg ? scn_lvl : sgl_lvl) && cnt_reg == 12'(TIMED_EXTRA_CYC)) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg == 12'h0 ||
                     cnt_reg == 12'(TIMED_EXTRA_CYC)) begin
          if (cnt_reg == 12'h0 || !(cur_scan_reg ? scn_lvl : sgl_lvl)) begin
            cnt_next = 12'(SAR_CYC);
            st_next = ST_SAR;
          end
          if (cnt_reg == 12'(TIMED_EXTRA_CYC)) begin
            cnt_next = 12'h1;
            st_next = ST_HOLD;
          end
        end else begin
          cnt_next = 12'(SAR_CYC);
          st_next = ST_SAR;
        end
      end
      ST_SAR: begin
        // Single in progress is not aborted by a scan
        if (cnt_reg == 12'h0) begin
          done_next = 1'b1;
          clk_req_next = 1'b0;
          st_next = ST_IDLE;
          if (cur_scan_reg) begin
            tail_wait_next = 1'b0;
            scn_act_next = scn_cfg_reg[REPEAT_BIT];
          end else begin
            sgl_act_next = sgl_cfg_reg[REPEAT_BIT];
          end
        end else begin
          cnt_next = cnt_reg - 12'h1;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // Stop drops the mode and any partial result
    if (sgl_stop) begin
      sgl_act_next = 1'b0;
      tail_wait_next = 1'b0;
      if (st_reg != ST_IDLE && !cur_scan_reg) begin
        disc_next = 1'b1;
        clk_req_next = 1'b0;
        st_next = ST_IDLE;
      end
    end
    if (scn_stop) begin
      scn_act_next = 1'b0;
      if (st_reg != ST_IDLE && cur_scan_reg) begin
        disc_next = 1'b1;
        clk_req_next = 1'b0;
        st_next = ST_IDLE;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      st_reg <= ST_IDLE;
      sgl_act_reg <= 1'b0;
      scn_act_reg <= 1'b0;
      cur_scan_reg <= 1'b0;
      tail_wait_reg <= 1'b0;
      clk_req_reg <= 1'b0;
      cnt_reg <= 12'h0;
      done_reg <= 1'b0;
      disc_reg <= 1'b0;
      phase_rst_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sgl_act_reg <= sgl_act_next;
      scn_act_reg <= scn_act_next;
      cur_scan_reg <= cur_scan_next;
      tail_wait_reg <= tail_wait_next;
      clk_req_reg <= clk_req_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      disc_reg <= disc_next;
      phase_rst_reg <= phase_rst_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdat_reg;
  assign O_CLK_REQ = clk_req_reg;
  assign O_ANALOG_EN = ctrl_reg[ENABLE_BIT] | (st_reg == ST_ACQ) |
                       (st_reg == ST_HOLD) | (st_reg == ST_SAR);
  assign O_SAMPLE = (st_reg == ST_ACQ) | (st_reg == ST_HOLD);
  assign O_SAR_PHASE_RST = phase_rst_reg;
  assign O_CONV_DONE = done_reg;
  assign O_CONV_IS_SCAN = cur_scan_reg;
  assign O_DISCARD_PARTIAL = disc_reg;
  assign O_SINGLE_FLUSH = cmd[SINGLE_FLUSH_BIT];
  assign O_SCAN_FLUSH = cmd[SCAN_FLUSH_BIT];
  assign O_REF_FAULT_CLEAR = bias_reg[FAULT_CLR_BIT];

  // ****************************************
  // Checks
  // ****************************************
  property p_start_wins;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (cmd[SINGLE_GO_BIT] && cmd[SINGLE_HALT_BIT] && !sgl_act_reg)
      |=> sgl_act_reg;
  endproperty
  a_start_wins: assert property (p_start_wins)
    else $error("start did not win over stop");

  property p_scan_first;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (st_reg == ST_IDLE && scn_act_reg && sgl_act_reg) |=> cur_scan_reg;
  endproperty
  a_scan_first: assert property (p_scan_first)
    else $error("scan not served first");

  property p_no_abort;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (st_reg == ST_SAR && !cur_scan_reg && !sgl_stop) |=> !cur_scan_reg;
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("scan aborted a single");

  property p_phase_rst;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (st_reg == ST_IDLE && st_next == ST_CLKWAIT) |=> O_SAR_PHASE_RST;
  endproperty
  a_phase_rst: assert property (p_phase_rst)
    else $error("phase reset missing");

  property p_act_on_write;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (cmd[SCAN_GO_BIT] && !scn_act_reg) |=> scn_act_reg;
  endproperty
  a_act_on_write: assert property (p_act_on_write)
    else $error("scan active flag not set");

  property p_discard;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (scn_stop && st_reg != ST_IDLE && cur_scan_reg) |=>
      (O_DISCARD_PARTIAL && st_reg == ST_IDLE);
  endproperty
  a_discard: assert property (p_discard)
    else $error("partial result not discarded");

  property p_clk_req;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (st_reg == ST_IDLE && st_next == ST_CLKWAIT && ctrl_reg[DEMAND_BIT])
      |=> O_CLK_REQ;
  endproperty
  a_clk_req: assert property (p_clk_req)
    else $error("clock request not raised");

  property p_one_shot;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
    (st_reg == ST_SAR && cnt_reg == 12'h0 && !cur_scan_reg &&
     !sgl_cfg_reg[REPEAT_BIT] && !sgl_trig) |=> !sgl_act_reg;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot single stayed active");
endmodule
`default_nettype wire

/* File: src/adc_seq_pkg.sv */
// Package with constants for the conversion sequencer
package adc_seq_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SINGLE_CFG_OFS = 8'h08;
  localparam logic [7:0] SCAN_CFG_OFS = 8'h0C;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] BIAS_OFS = 8'h14;

  // ****************************************
  // Command register bits
  // ****************************************
  localparam int SINGLE_GO_BIT = 0;
  localparam int SINGLE_HALT_BIT = 1;
  localparam int SCAN_GO_BIT = 2;
  localparam int SCAN_HALT_BIT = 3;
  localparam int SINGLE_FLUSH_BIT = 4;
  localparam int SCAN_FLUSH_BIT = 5;

  // ****************************************
  // Status register bits
  // ****************************************
  localparam int SINGLE_ACT_BIT = 0;
  localparam int SCAN_ACT_BIT = 1;
  localparam int CLK_REQ_BIT = 2;
  localparam int ANALOG_EN_BIT = 3;
  localparam int BUSY_SINGLE_BIT = 4;
  localparam int BUSY_SCAN_BIT = 5;

  // ****************************************
  // Mode config fields (single and scan alike)
  // ****************************************
  localparam int REPEAT_BIT = 0;
  localparam int TRIG_EN_BIT = 1;
  localparam int TRIG_STYLE_BIT = 2;
  localparam int CHSEL_LSB = 4;
  localparam int CHSEL_W = 4;
  localparam int AT_LSB = 8;
  localparam int AT_W = 8;
  localparam int DLY_LSB = 16;
  localparam int DLY_W = 4;
  localparam int DLY_EN_BIT = 20;
  localparam int CFG_W = 21;
  localparam logic [CFG_W-1:0] CFG_RST = 21'h000000;

  // ****************************************
  // Control and bias fields
  // ****************************************
  localparam int TAIL_BIT = 0;
  localparam int DEMAND_BIT = 1;
  localparam int ENABLE_BIT = 2;
  localparam int BIAS_LSB = 0;
  localparam int BIAS_W = 4;
  localparam int FAULT_CLR_BIT = 8;
  localparam logic [BIAS_W-1:0] BIAS_RST = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int DLY_MAX_US = 8;
  localparam int CLK_START_CYC = 5;
  localparam int OSC_START_CYC = 7;
  localparam int TIMED_EXTRA_CYC = 2;
  localparam int SAR_CYC = 13;
  localparam int NUM_CH = 16;

  typedef enum {
    ST_IDLE,
    ST_CLKWAIT,
    ST_DELAY,
    ST_ACQ,
    ST_HOLD,
    ST_SAR
  } seq_state_t;

endpackage

/* File: src/adc_trig_sync.sv */
// Two-flop synchroniser for an event channel with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module adc_trig_sync
  import adc_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [NUM_CH-1:0] i_async,
  input wire logic [CHSEL_W-1:0] i_sel,
  output logic o_level,
  output logic o_rise
);
  logic [NUM_CH-1:0] s1_reg, s1_next;
  logic [NUM_CH-1:0] s2_reg, s2_next;
  logic lvl_reg, lvl_next;

  always_comb begin
    s1_next = i_async;
    s2_next = s1_reg;
    lvl_next = s2_reg[i_sel];
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;
  assign o_rise = lvl_next & ~lvl_reg;
endmodule
`default_nettype wire

/* File: src/adc_bias_scale.sv */
// Bias scale factor from the bias program field, in 1/32 units
`timescale 1ns/1ps
`default_nettype none
module adc_bias_scale
  import adc_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [BIAS_W-1:0] i_field,
  output logic [5:0] o_scale
);
  logic [5:0] scale_reg, scale_next;
  logic [5:0] base;

  // Factor (8 - low3)/8 times 32, divided by four when bit 3 is set
  always_comb begin
    base = 6'(({3'h0, 3'h0} + 6'd8 - {3'h0, i_field[2:0]}) << 2);
    scale_next = i_field[3] ? (base >> 2) : base;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scale_reg <= 6'h20;
    end else begin
      scale_reg <= scale_next;
    end
  end

  assign o_scale = scale_reg;
endmodule
`default_nettype wire

/* File: bench/adc_event_partner.sv */
// Event network and oscillator model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_event_partner (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_fire,
  input wire logic [3:0] i_ch,
  input wire logic [7:0] i_len,
  input wire logic i_clk_req,
  output logic [15:0] o_event,
  output logic o_osc_running
);
  logic [7:0] cnt_reg;
  logic [3:0] ch_reg;
  // ****************************************
  // Pulse generator and oscillator start
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= 8'h00;
      ch_reg <= 4'h0;
    end else if (i_fire) begin
      cnt_reg <= i_len;
      ch_reg <= i_ch;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
    o_osc_running <= i_clk_req & ~i_srst;
  end
  // Pulse on one channel, length set per shot
  assign o_event = (cnt_reg != 8'h00) ? (16'h0001 << ch_reg) : 16'h0000;
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_seq_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic fire = 1'b0;
  logic [3:0] ch = 4'h0;
  logic [7:0] len = 8'h00;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] seed = 32'h9913;
  logic [31:0] rdat, q, f;
  logic [15:0] ev;
  logic ack, creq, done, is_scan, fclr, osc, smp;
  logic aen, prst, disc, sfl, cfl;
  logic [5:0] bscale;
  logic [31:0] rd_q[$];
  logic [31:0] mk_q[$];
  logic cv_q[$];
  int error_cnt = 0;
  int checked = 0;
  int dn = 0;
  int nprst = 0;
  int ndisc = 0;
  int nfl = 0;
  int n;
  adc_conv_seq uut (.I_SYS_CLK(clk), .I_SRST(srst), .I_WB_ADR(adr),
    .I_WB_DAT(wdat), .I_WB_SEL(sel), .I_WB_WE(we), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EVENT(ev),
    .I_OSC_RUNNING(osc), .I_REF_OVERVOLTAGE(1'b0), .O_CLK_REQ(creq),
    .O_ANALOG_EN(aen), .O_SAMPLE(smp), .O_SAR_PHASE_RST(prst),
    .O_CONV_DONE(done), .O_CONV_IS_SCAN(is_scan),
    .O_DISCARD_PARTIAL(disc), .O_SINGLE_FLUSH(sfl),
    .O_SCAN_FLUSH(cfl), .O_BIAS_SCALE(bscale), .O_REF_FAULT_CLEAR(fclr));
  adc_event_partner prt (.i_clk(clk), .i_srst(srst), .i_fire(fire),
    .i_ch(ch), .i_len(len), .i_clk_req(creq), .o_event(ev),
    .o_osc_running(osc));
  initial begin
    forever #5 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic [31:0] d,
                    input logic w);
    int k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    we <= w;
    @(posedge clk);
    while (ack !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk);
    end
    if (k >= 50) begin
      error_cnt++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    rd_q.push_back(e);
    mk_q.push_back(m);
    wb(a, 32'h0, 1'b0);
  endtask
  task automatic wait_for(input int tgt);
    n = 0;
    while (dn < tgt && n < 600) begin
      n++;
      @(posedge clk);
    end
    check(dn, tgt);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // Result monitor
  // ****************************************
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1 &&
        rd_q.size() > 0) begin
      check(rdat & mk_q.pop_front(), rd_q.pop_front());
    end
    if (smp === 1'b1) begin
      check(aen, 1'b1);
    end
    nprst += int'(prst === 1'b1);
    ndisc += int'(disc === 1'b1);
    nfl += int'(sfl === 1'b1) + int'(cfl === 1'b1);
    if (done === 1'b1) begin
      dn++;
      if (cv_q.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        check(is_scan, cv_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(bscale, 32'h20);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      f = rnd() & 32'hF;
      wb(BIAS_OFS, 32'h100 | f, 1'b1);
      repeat (2) @(posedge clk);
      check(fclr, 1'b1);
      check(bscale, f[3] ? 32'h8 - f[2:0] : (32'h8 - f[2:0]) * 4);
      wb(BIAS_OFS, f, 1'b1);
      repeat (2) @(posedge clk);
      check(fclr, 1'b0);
    end
    $display("Test bias done");
    wb(SINGLE_CFG_OFS, (rnd() & 32'h3) << AT_LSB, 1'b1);
    cv_q.push_back(1'b0);
    wb(CMD_OFS, 32'h3, 1'b1);
    rd(STATUS_OFS, 32'h1, 32'h1);
    wb(CMD_OFS, 32'h1, 1'b1);
    wait_for(1);
    repeat (60) @(posedge clk);
    check(dn, 1);
    rd(STATUS_OFS, 32'h0, 32'h3F);
    cv_q.push_back(1'b1);
    cv_q.push_back(1'b0);
    wb(CMD_OFS, 32'h5, 1'b1);
    wait_for(3);
    cv_q.push_back(1'b0);
    cv_q.push_back(1'b1);
    wb(CMD_OFS, 32'h1, 1'b1);
    n = 0;
    while (smp !== 1'b1 && n < 99) begin
      n++;
      @(posedge clk);
    end
    check(smp, 1'b1);
    wb(CMD_OFS, 32'h4, 1'b1);
    wait_for(5);
    $display("Test priority done");
    wb(CTRL_OFS, 32'h1, 1'b1);
    cv_q.push_back(1'b1);
    cv_q.push_back(1'b0);
    wb(CMD_OFS, 32'h1, 1'b1);
    repeat (80) @(posedge clk);
    check(dn, 5);
    wb(CMD_OFS, 32'h4, 1'b1);
    wait_for(7);
    $display("Test tail follow done");
    wb(CTRL_OFS, 32'h2, 1'b1);
    wb(SINGLE_CFG_OFS, 32'h1, 1'b1);
    cv_q.push_back(1'b0);
    cv_q.push_back(1'b0);
    wb(CMD_OFS, 32'h1, 1'b1);
    wait_for(9);
    wb(CMD_OFS, 32'h2, 1'b1);
    n = 0;
    q = 32'h1;
    while (q[SINGLE_ACT_BIT] !== 1'b0 && n < 99) begin
      wb(STATUS_OFS, 32'h0, 1'b0);
      n++;
    end
    check(q[SINGLE_ACT_BIT], 1'b0);
    check(ndisc, 1);
    wb(CMD_OFS, 32'h30, 1'b1);
    check(nfl, 2);
    $display("Test repeat done");
    f = rnd() & 32'hF;
    ch <= f[3:0];
    wb(SINGLE_CFG_OFS, (f << CHSEL_LSB) | 32'h110002, 1'b1);
    cv_q.push_back(1'b0);
    fire <= 1'b1;
    len <= 8'h03;
    @(posedge clk);
    fire <= 1'b0;
    repeat (100) @(posedge clk);
    check(dn, 9);
    check(aen, 1'b0);
    wait_for(10);
    wb(SINGLE_CFG_OFS, 32'h0, 1'b1);
    wb(SCAN_CFG_OFS, (ch << CHSEL_LSB) | 32'h206, 1'b1);
    cv_q.push_back(1'b1);
    fire <= 1'b1;
    len <= 8'h30;
    @(posedge clk);
    fire <= 1'b0;
    wait_for(11);
    cv_q.push_back(1'b1);
    fire <= 1'b1;
    len <= 8'h04;
    @(posedge clk);
    fire <= 1'b0;
    wait_for(12);
    check(nprst, 13);
    $display("Test event done");
    stop_test();
  end
endmodule
`default_nettype wire
